// >>> lcm_pkg.sv
// Notes on behaviour
// - cycle-duration mode takes 1..240 hours and 1..10 strokes per cycle.
// - emptying-time mode takes 1..24 whole months.
// - emptying-time mode computes its own cycle duration from the months.
// - pulse mode bursts on external controller commands and on priming, not the timer.
// - a cycle is one gapless burst of up to ten strokes, then a pause.
// - next cycle starts by itself once the cycle duration has elapsed.
// - reset gives cycle-duration mode, small cartridge and switched off.
// - cartridge size is one of two volumes, small or large.
// - info menu only while off, shows settings, changes nothing.
// - manual check only while on, selecting it starts one burst at once.
// - settings menu only while on.
// - priming only while on, runs one burst of exactly 40 strokes.
// - on/off toggle appears at more than one menu position.
// - key indicator shows while the key is sensed.
// - idle on or off state enters screen saver after 10 seconds.
// - with key held, menu items step in fixed order every 2 seconds.
// - lifting the key selects the shown item and clears the indicator.
// - settings and on/off state change, and menu actions trigger, only through the key.
// - after the info presentation the block returns to switched off.
package lcm_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ     = 40_000_000;
  localparam int STEP_S     = 2;
  localparam int SAVER_S    = 10;
  localparam int DEB_MS     = 20;
  localparam int FLASH_MS   = 250;
  localparam int STROKE_MS  = 1000;
  localparam int SEC_CYC    = CLK_HZ;
  localparam int STEP_CYC   = STEP_S * CLK_HZ;
  localparam int SAVER_CYC  = SAVER_S * CLK_HZ;
  localparam int DEB_CYC    = DEB_MS * (CLK_HZ / 1000);
  localparam int FLASH_CYC  = FLASH_MS * (CLK_HZ / 1000);
  localparam int STROKE_CYC = STROKE_MS * (CLK_HZ / 1000);
  localparam int INFO_PAGES = 4;
  // ----------------------------------------------------------------
  // limits and derivation
  // ----------------------------------------------------------------
  localparam logic [7:0]  HOURS_MAX    = 8'hF0;
  localparam logic [3:0]  STROKES_MAX  = 4'hA;
  localparam logic [4:0]  MONTHS_MAX   = 5'h18;
  localparam logic [5:0]  FILL_STROKES = 6'h28;
  localparam logic [11:0] SEC_PER_HOUR = 12'hE10;
  localparam logic [11:0] EMPTY_K_SML  = 12'hC27;  // s per month, 833 strokes
  localparam logic [11:0] EMPTY_K_LRG  = 12'h613;  // s per month, 1666 strokes
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  HOURS_RST    = 8'h18;
  localparam logic [3:0]  STROKES_RST  = 4'h1;
  localparam logic [4:0]  MONTHS_RST   = 5'h0C;
  localparam logic [19:0] CYC_S_RST    = 20'h15180;
  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_STAGE  = 4'h4;
  localparam logic [3:0] REG_ACTIVE = 4'h8;
  localparam logic [3:0] REG_COUNT  = 4'hC;
  localparam int F_HOURS   = 0;
  localparam int F_STROKES = 8;
  localparam int F_MONTHS  = 12;
  localparam int F_MODE    = 17;
  localparam int F_CART    = 19;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_CYCLE = 2'b00,
    MODE_EMPTY = 2'b01,
    MODE_PULSE = 2'b10
  } lcm_mode_e;
  typedef enum logic [2:0] {
    ITM_NONE  = 3'b000,
    ITM_ON    = 3'b001,
    ITM_OFF   = 3'b010,
    ITM_INFO  = 3'b011,
    ITM_CHECK = 3'b100,
    ITM_SET   = 3'b101,
    ITM_FILL  = 3'b110
  } lcm_item_e;
endpackage

// >>> lcm_ctrl.sv
module lcm_ctrl #(
  parameter int SEC_CYC    = lcm_pkg::SEC_CYC,
  parameter int STEP_CYC   = lcm_pkg::STEP_CYC,
  parameter int SAVER_CYC  = lcm_pkg::SAVER_CYC,
  parameter int DEB_CYC    = lcm_pkg::DEB_CYC,
  parameter int FLASH_CYC  = lcm_pkg::FLASH_CYC,
  parameter int STROKE_CYC = lcm_pkg::STROKE_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        key_in,
  input  wire logic        plc_cmd,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             pump_run,
  output logic             key_ind,
  output logic             confirm_ind,
  output logic             disp_blank,
  output logic             saver,
  output logic      [2:0]  menu_item,
  output logic             dev_on,
  output logic             info_act,
  output logic      [1:0]  info_page
);
  // ----------------------------------------------------------------
  // menu decode
  // ----------------------------------------------------------------
  // item shown at step idx for the current on/off state and mode
  function automatic lcm_pkg::lcm_item_e item_of(input logic on, input logic [2:0] idx,
                                                  input logic [1:0] md);
    lcm_pkg::lcm_item_e it;
    it = lcm_pkg::ITM_NONE;
    if (on)
    begin
      unique case (idx)
        3'h1: it = lcm_pkg::ITM_OFF;
        3'h2: it = (md == lcm_pkg::MODE_PULSE) ? lcm_pkg::ITM_NONE : lcm_pkg::ITM_CHECK;
        3'h3: it = lcm_pkg::ITM_SET;
        3'h4: it = lcm_pkg::ITM_FILL;
        3'h5: it = lcm_pkg::ITM_OFF;
        default: it = lcm_pkg::ITM_NONE;
      endcase
    end
    else
    begin
      unique case (idx)
        3'h1: it = lcm_pkg::ITM_ON;
        3'h2: it = lcm_pkg::ITM_INFO;
        3'h3: it = lcm_pkg::ITM_ON;
        default: it = lcm_pkg::ITM_NONE;
      endcase
    end
    return it;
  endfunction

  logic        sync1_q, sync2_q, key_db_q, key_prev_q;
  logic [25:0] deb_q;
  logic [27:0] step_q;
  logic [2:0]  idx_q;
  logic        on_q, cart_q, info_q;
  logic [1:0]  mode_q, page_q;
  logic [7:0]  hours_q;
  logic [3:0]  strokes_q;
  logic [4:0]  months_q;
  logic [19:0] cyc_s_q, sec_cnt_q;
  logic [31:0] stage_q;
  logic [25:0] pre_q;
  logic [27:0] info_tmr_q;
  logic [5:0]  left_q;
  logic [25:0] stk_tmr_q;
  logic [15:0] done_q;
  logic [2:0]  flash_q;
  logic [23:0] flash_tmr_q;
  logic [29:0] idle_q;
  logic        saver_q;
  logic [31:0] rdata_q;

  // ----------------------------------------------------------------
  // key sync, debounce and stepping
  // ----------------------------------------------------------------
  wire key_chg  = (sync2_q != key_db_q);
  wire key_rise = key_db_q & ~key_prev_q;
  wire key_fall = ~key_db_q & key_prev_q;
  wire lcm_pkg::lcm_item_e cur_item = item_of(on_q, idx_q, mode_q);
  wire sel      = key_fall & (cur_item != lcm_pkg::ITM_NONE) & ~info_q;
  wire sel_on   = sel & (cur_item == lcm_pkg::ITM_ON);
  wire sel_off  = sel & (cur_item == lcm_pkg::ITM_OFF);
  wire sel_info = sel & (cur_item == lcm_pkg::ITM_INFO);
  wire sel_chk  = sel & (cur_item == lcm_pkg::ITM_CHECK);
  wire sel_set  = sel & (cur_item == lcm_pkg::ITM_SET);
  wire sel_fill = sel & (cur_item == lcm_pkg::ITM_FILL);

  // two-flop synchroniser, then hold-off until stable
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      key_db_q <= 1'b0;
      key_prev_q <= 1'b0;
      deb_q <= '0;
    end
    else if (ce)
    begin
      sync1_q <= key_in;
      sync2_q <= sync1_q;
      key_prev_q <= key_db_q;
      deb_q <= key_chg ? deb_q + 26'h1 : '0;
      if (key_chg && deb_q == 26'(DEB_CYC - 1))
        key_db_q <= sync2_q;
    end
  end

  // step index advances every STEP_CYC while key held
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      step_q <= '0;
      idx_q <= 3'h0;
    end
    else if (ce)
    begin
      if (!key_db_q || key_rise)
      begin
        step_q <= '0;
        idx_q <= key_fall ? idx_q : 3'h0;
      end
      else if (step_q == 28'(STEP_CYC - 1))
      begin
        step_q <= '0;
        if (idx_q != 3'h6)
          idx_q <= idx_q + 3'h1;  // saturates past the last item
      end
      else
        step_q <= step_q + 28'h1;
    end
  end

  // ----------------------------------------------------------------
  // settings
  // ----------------------------------------------------------------
  wire [7:0] stg_hours   = stage_q[lcm_pkg::F_HOURS +: 8];
  wire [3:0] stg_strokes = stage_q[lcm_pkg::F_STROKES +: 4];
  wire [4:0] stg_months  = stage_q[lcm_pkg::F_MONTHS +: 5];
  wire [1:0] stg_mode    = stage_q[lcm_pkg::F_MODE +: 2];
  wire       stg_cart    = stage_q[lcm_pkg::F_CART];
  wire ok_cyc  = stg_hours != 8'h0 && stg_hours <= lcm_pkg::HOURS_MAX
               && stg_strokes != 4'h0 && stg_strokes <= lcm_pkg::STROKES_MAX;
  wire ok_emp  = stg_months != 5'h0 && stg_months <= lcm_pkg::MONTHS_MAX;
  wire ok_mode = (stg_mode == lcm_pkg::MODE_CYCLE && ok_cyc)
               || (stg_mode == lcm_pkg::MODE_EMPTY && ok_emp)
               || stg_mode == lcm_pkg::MODE_PULSE;
  wire [11:0] emp_k = stg_cart ? lcm_pkg::EMPTY_K_LRG : lcm_pkg::EMPTY_K_SML;
  wire [19:0] cyc_from_h = 20'(stg_hours * lcm_pkg::SEC_PER_HOUR);
  wire [19:0] cyc_from_m = 20'(stg_months * emp_k);
  wire        apply      = sel_set & ok_mode;        // key selection only
  localparam logic [3:0] STROKES_ONE = 4'h1;         // emptying mode doses one stroke

  // staged values from software take effect only on key-confirmed settings
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      stage_q <= '0;
      mode_q <= lcm_pkg::MODE_CYCLE;
      cart_q <= 1'b0;                 // small cartridge
      hours_q <= lcm_pkg::HOURS_RST;
      strokes_q <= lcm_pkg::STROKES_RST;
      months_q <= lcm_pkg::MONTHS_RST;
      cyc_s_q <= lcm_pkg::CYC_S_RST;
    end
    else if (ce)
    begin
      if (reg_wr && reg_addr == lcm_pkg::REG_STAGE)
        stage_q <= {12'h0, reg_wdata[19:0]};
      if (apply)
      begin
        mode_q <= stg_mode;
        cart_q <= stg_cart;
        if (stg_mode == lcm_pkg::MODE_CYCLE)
        begin
          hours_q <= stg_hours;
          strokes_q <= stg_strokes;
          cyc_s_q <= cyc_from_h;
        end
        else if (stg_mode == lcm_pkg::MODE_EMPTY)
        begin
          months_q <= stg_months;
          strokes_q <= STROKES_ONE;
          cyc_s_q <= cyc_from_m;
        end
      end
    end
  end

  // on/off and info presentation
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      on_q <= 1'b0;
      info_q <= 1'b0;
      info_tmr_q <= '0;
      page_q <= 2'h0;
    end
    else if (ce)
    begin
      if (sel_on)
        on_q <= 1'b1;
      else if (sel_off)
        on_q <= 1'b0;
      if (sel_info)
      begin
        info_q <= 1'b1;
        info_tmr_q <= '0;
        page_q <= 2'h0;
      end
      else if (info_q)
      begin
        if (info_tmr_q == 28'(STEP_CYC - 1))
        begin
          info_tmr_q <= '0;
          page_q <= page_q + 2'h1;
          if (page_q == 2'(lcm_pkg::INFO_PAGES - 1))
            info_q <= 1'b0;  // back to plain off
        end
        else
          info_tmr_q <= info_tmr_q + 28'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // cycle scheduler and pump burst
  // ----------------------------------------------------------------
  wire sec_tick  = (pre_q == 26'(SEC_CYC - 1));
  wire timed     = on_q & (mode_q != lcm_pkg::MODE_PULSE);
  wire due       = timed & sec_tick & (sec_cnt_q + 20'h1 >= cyc_s_q);
  wire start_on  = sel_on & (mode_q != lcm_pkg::MODE_PULSE);
  wire plc_go    = on_q & (mode_q == lcm_pkg::MODE_PULSE) & plc_cmd;
  wire busy      = (left_q != 6'h0);
  wire [5:0] req_n = sel_fill ? lcm_pkg::FILL_STROKES : {2'b00, strokes_q};
  wire req       = sel_fill | sel_chk | due | start_on | plc_go;

  // seconds since the current cycle began; prescaler restarts with each cycle
  // so the period is exact and not short by up to one second
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pre_q <= '0;
      sec_cnt_q <= '0;
    end
    else if (ce)
    begin
      pre_q <= (sec_tick || start_on || !timed) ? '0 : pre_q + 26'h1;
      if (!timed || start_on || due)
        sec_cnt_q <= '0;  // cycle restarts its clock
      else if (sec_tick)
        sec_cnt_q <= sec_cnt_q + 20'h1;
    end
  end

  // strokes back to back, no gap while left_q nonzero
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      left_q <= 6'h0;
      stk_tmr_q <= '0;
      done_q <= '0;
    end
    else if (ce)
    begin
      if (!busy && req)
      begin
        left_q <= req_n;
        stk_tmr_q <= '0;
      end
      else if (busy)
      begin
        if (stk_tmr_q == 26'(STROKE_CYC - 1))
        begin
          stk_tmr_q <= '0;
          left_q <= left_q - 6'h1;
          done_q <= done_q + 16'h1;
        end
        else
          stk_tmr_q <= stk_tmr_q + 26'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // display indicators
  // ----------------------------------------------------------------
  // four half periods: blank, lit, blank, lit
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      flash_q <= 3'h0;
      flash_tmr_q <= '0;
    end
    else if (ce)
    begin
      if (sel)
      begin
        flash_q <= 3'h4;
        flash_tmr_q <= '0;
      end
      else if (flash_q != 3'h0)
      begin
        if (flash_tmr_q == 24'(FLASH_CYC - 1))
        begin
          flash_tmr_q <= '0;
          flash_q <= flash_q - 3'h1;
        end
        else
          flash_tmr_q <= flash_tmr_q + 24'h1;
      end
    end
  end

  wire activity = key_db_q | info_q | (flash_q != 3'h0) | busy;

  // screen saver after idle time
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      idle_q <= '0;
      saver_q <= 1'b0;
    end
    else if (ce)
    begin
      if (activity)
      begin
        idle_q <= '0;
        saver_q <= 1'b0;
      end
      else if (idle_q == 30'(SAVER_CYC - 1))
        saver_q <= 1'b1;
      else
        idle_q <= idle_q + 30'h1;
    end
  end

  // ----------------------------------------------------------------
  // status read port
  // ----------------------------------------------------------------
  wire [31:0] st_word = {22'h0, info_q, busy, cur_item, key_db_q, cart_q, mode_q, on_q};
  wire [31:0] act_word = {12'h0, cart_q, mode_q, months_q, strokes_q, hours_q};
  wire [31:0] rd_mux =
    (reg_addr == lcm_pkg::REG_STATUS) ? st_word :
    (reg_addr == lcm_pkg::REG_STAGE)  ? stage_q :
    (reg_addr == lcm_pkg::REG_ACTIVE) ? act_word :
    (reg_addr == lcm_pkg::REG_COUNT)  ? {16'h0, done_q} : 32'h0;

  // read data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rdata_q <= '0;
    else if (ce)
      rdata_q <= reg_rd ? rd_mux : 32'h0;
  end

  assign reg_rdata   = rdata_q;
  assign pump_run    = busy;
  assign key_ind     = key_db_q;
  assign confirm_ind = (flash_q != 3'h0);
  assign disp_blank  = flash_q[0] == 1'b0 && flash_q != 3'h0;
  assign saver       = saver_q;
  assign menu_item   = key_db_q ? cur_item : lcm_pkg::ITM_NONE;
  assign dev_on      = on_q;
  assign info_act    = info_q;
  assign info_page   = page_q;
endmodule

// >>> lcm_chk_sva.sv
module lcm_chk #(
  parameter int STEP_CYC   = 40,
  parameter int FLASH_CYC  = 8,
  parameter int STROKE_CYC = 10
) (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       key_in,
  input wire logic       pump_run,
  input wire logic       key_ind,
  input wire logic       confirm_ind,
  input wire logic       disp_blank,
  input wire logic       saver,
  input wire logic [2:0] menu_item,
  input wire logic       dev_on,
  input wire logic       info_act,
  input wire logic [1:0] info_page
);
  // ------------------------------------------------------------
  // helper counters
  // ------------------------------------------------------------
  logic [2:0]  item_q;
  logic [15:0] hold_q;
  logic [15:0] run_q;
  logic [15:0] conf_q;
  // how long the shown item, the burst and the confirm window have lasted
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      item_q <= 3'h0;
      hold_q <= 16'h0;
      run_q  <= 16'h0;
      conf_q <= 16'h0;
    end
    else
    begin
      item_q <= menu_item;
      hold_q <= (menu_item != item_q) ? 16'h1 : hold_q + 16'h1;
      run_q  <= pump_run ? run_q + 16'h1 : 16'h0;
      conf_q <= confirm_ind ? conf_q + 16'h1 : 16'h0;
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  a_key_debounced: assert property ($rose(key_ind) |-> $past(key_in, 3))
    else $error("key indicator rose without a steady key");
  a_key_cleared: assert property ($fell(key_ind) |-> !$past(key_in, 3))
    else $error("key indicator fell while key present");
  a_onoff_by_key: assert property ($changed(dev_on) |-> $past(key_ind, 2) || $past(key_ind, 3))
    else $error("on state changed without key");
  a_step_period: assert property (key_ind && menu_item != item_q && item_q != 3'h0
    |-> hold_q == 16'(STEP_CYC))
    else $error("menu step period wrong");
  a_burst_whole: assert property ($fell(pump_run)
    |-> run_q % STROKE_CYC == 0 && run_q <= 16'(40 * STROKE_CYC))
    else $error("burst not whole strokes");
  a_confirm_span: assert property ($fell(confirm_ind) |-> conf_q == 16'(4 * FLASH_CYC))
    else $error("confirm window length wrong");
  a_flash_twice: assert property ($rose(confirm_ind) |-> disp_blank ##(FLASH_CYC) !disp_blank
    ##(FLASH_CYC) disp_blank ##(FLASH_CYC) !disp_blank)
    else $error("display did not flash twice");
  a_select_on: assert property ($fell(key_ind) && $past(menu_item) == lcm_pkg::ITM_ON && !dev_on
    |=> dev_on && confirm_ind)
    else $error("on item not taken on release");
  a_check_starts: assert property ($fell(key_ind) && $past(menu_item) == lcm_pkg::ITM_CHECK
    && !pump_run |=> pump_run)
    else $error("check did not start a burst");
  a_fill_starts: assert property ($fell(key_ind) && $past(menu_item) == lcm_pkg::ITM_FILL
    && !pump_run |=> pump_run [*8])
    else $error("fill did not start a burst");
  a_on_menus: assert property (menu_item inside {lcm_pkg::ITM_CHECK, lcm_pkg::ITM_SET,
    lcm_pkg::ITM_FILL} |-> dev_on)
    else $error("on-only item offered while off");
  a_info_off: assert property (menu_item == lcm_pkg::ITM_INFO || info_act |-> !dev_on)
    else $error("info offered while on");
  a_saver_idle: assert property ($rose(saver) |-> !key_ind && !pump_run && !info_act)
    else $error("saver entered while busy");
  a_info_pages: assert property ($fell(info_act) |-> $past(info_page) == 2'h3)
    else $error("info ended before its last page");
endmodule

bind lcm_ctrl lcm_chk #(.STEP_CYC(STEP_CYC), .FLASH_CYC(FLASH_CYC), .STROKE_CYC(STROKE_CYC))
  chk_u (.clk_sys, .rst, .key_in, .pump_run, .key_ind, .confirm_ind, .disp_blank, .saver,
         .menu_item, .dev_on, .info_act, .info_page);

// >>> lcm_operator.sv
module lcm_operator (
  input  wire logic       clk_sys,
  input  wire logic [2:0] menu_item,
  output logic            key_in,
  output logic            plc_cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------------------------------------
  // operator with key and external controller
  // ------------------------------------------------------------
  // key lifted and controller quiet at start
  initial
  begin
    key_in  = 1'b0;
    plc_cmd = 1'b0;
  end
  // brief touch, shorter than the debounce span
  task automatic tap();
    @(posedge clk_sys);
    key_in <= 1'b1;
    @(posedge clk_sys);
    key_in <= 1'b0;
  endtask
  // bouncy press, hold until the wanted item shows, then lift
  task automatic pick(input logic [2:0] code);
    int n;
    tap();
    @(posedge clk_sys);
    key_in <= 1'b1;
    repeat (10) @(negedge clk_sys);
    n = 0;
    while (menu_item !== code && n < 600)
    begin
      @(negedge clk_sys);
      n++;
    end
    @(posedge clk_sys);
    key_in <= 1'b0;
  endtask
  // one command pulse from the controller
  task automatic plc_pulse();
    @(posedge clk_sys);
    plc_cmd <= 1'b1;
    @(posedge clk_sys);
    plc_cmd <= 1'b0;
  endtask
endmodule

// >>> lubricator_cycle_menu_control_bench.sv
module lubricator_cycle_menu_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STK = 10;
  localparam int SEC = 2;
  logic        clk_sys;
  logic        rst;
  logic        key_in;
  logic        plc_cmd;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        pump_run;
  logic        key_ind;
  logic        confirm_ind;
  logic        disp_blank;
  logic        saver;
  logic [2:0]  menu_item;
  logic        dev_on;
  logic        info_act;
  logic [1:0]  info_page;
  int          error_cnt;
  int          n_compared;
  int          cyc = 0;
  int          t0;
  int          m_on, m_hr, m_st, m_mo, m_md, m_ct, m_cnt;
  // ------------------------------------------------------------
  // design, operator, clock
  // ------------------------------------------------------------
  lcm_ctrl #(.SEC_CYC(SEC), .STEP_CYC(40), .SAVER_CYC(200), .DEB_CYC(4), .FLASH_CYC(8),
    .STROKE_CYC(STK)) dut_u (.clk_sys, .rst, .ce(1'b1), .key_in, .plc_cmd, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .pump_run, .key_ind, .confirm_ind, .disp_blank,
    .saver, .menu_item, .dev_on, .info_act, .info_page);
  lcm_operator op_u (.clk_sys, .menu_item, .key_in, .plc_cmd);
  // free running clock and cycle count
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [31:0] pack(input int hr, st, mo, md, ct);
    return 32'((ct << 19) | (md << 17) | (mo << 12) | (st << 8) | hr);
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(negedge clk_sys);
    v = reg_rdata;
  endtask
  // status, live settings and stroke count against the model
  task automatic chk_regs();
    logic [31:0] v;
    rd(4'h0, v);
    chk(v, 32'(m_ct * 8 + m_md * 2 + m_on));
    rd(4'h8, v);
    chk(v, pack(m_hr, m_st, m_mo, m_md, m_ct));
    rd(4'hC, v);
    chk(v, 32'(m_cnt & 16'hFFFF));
  endtask
  // wait for a burst within lim cycles and measure its length
  task automatic burst(input int n, input int lim);
    int k;
    int len;
    k = 0;
    len = 0;
    while (pump_run !== 1'b1 && k < lim)
    begin
      @(negedge clk_sys);
      k++;
    end
    t0 = cyc;
    while (pump_run === 1'b1 && len < 500)
    begin
      @(negedge clk_sys);
      len++;
    end
    chk(32'(len), 32'(n * STK));
    m_cnt += n;
  endtask
  task automatic sel(input logic [2:0] code, input int n);
    op_u.pick(code);
    burst(n, 60);
    repeat (40) @(negedge clk_sys);
  endtask
  // next automatic burst must begin span cycles after the last one began
  task automatic period(input int span, input int n);
    int t;
    t = t0;
    burst(n, span + 100);
    chk(32'(t0 - t), 32'(span));
  endtask
  // ------------------------------------------------------------
  // watchdog and main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    chk(32'h1, 32'h0);
    summarize();
  end
  initial
  begin
    logic [31:0] v;
    int          s;
    error_cnt = 0;
    n_compared = 0;
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    m_on = 0;
    m_hr = 24;
    m_st = 1;
    m_mo = 12;
    m_md = 0;
    m_ct = 0;
    m_cnt = 0;
    void'($urandom(21));
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    chk_regs();
    rd(4'h2, v);
    chk(v, 32'h0);
    $display("reset test done");
    op_u.tap();
    repeat (20) @(negedge clk_sys);
    chk(32'(key_ind), 32'h0);
    sel(lcm_pkg::ITM_NONE, 0);
    chk_regs();
    $display("bounce and early release done");
    sel(lcm_pkg::ITM_INFO, 0);
    chk(32'(info_act), 32'h1);
    repeat (200) @(negedge clk_sys);
    chk_regs();
    repeat (220) @(negedge clk_sys);
    chk(32'(saver), 32'h1);
    $display("info and saver done");
    m_on = 1;
    sel(lcm_pkg::ITM_ON, m_st);
    op_u.plc_pulse();
    burst(0, 20);
    chk_regs();
    $display("switch on done");
    s = $urandom_range(10, 1);
    wr(4'h4, pack(1, s, 12, 0, 1));
    chk_regs();
    m_hr = 1;
    m_st = s;
    m_ct = 1;
    sel(lcm_pkg::ITM_SET, 0);
    chk_regs();
    wr(4'h4, pack(241, 11, 12, 0, 0));
    sel(lcm_pkg::ITM_SET, 0);
    chk_regs();
    $display("settings done");
    sel(lcm_pkg::ITM_CHECK, m_st);
    sel(lcm_pkg::ITM_FILL, 40);
    chk_regs();
    $display("check and fill done");
    m_on = 0;
    sel(lcm_pkg::ITM_OFF, 0);
    m_on = 1;
    sel(lcm_pkg::ITM_ON, m_st);
    period(3600 * SEC, m_st);
    $display("cycle period done");
    wr(4'h4, pack(1, m_st, 1, 1, 1));
    m_mo = 1;
    m_md = 1;
    m_st = 1;
    sel(lcm_pkg::ITM_SET, 0);
    m_on = 0;
    sel(lcm_pkg::ITM_OFF, 0);
    m_on = 1;
    sel(lcm_pkg::ITM_ON, 1);
    period(1555 * SEC, 1);
    chk_regs();
    $display("emptying mode done");
    wr(4'h4, pack(1, m_st, 1, 2, 1));
    m_md = 2;
    sel(lcm_pkg::ITM_SET, 0);
    op_u.plc_pulse();
    burst(m_st, 20);
    chk_regs();
    $display("pulse mode done");
    summarize();
  end
endmodule
